// ==== core/snp_pkg.sv ====
// Purpose: Shared constants and types of the serial-to-network packetizer.
// Assumes: 250 MHz system clock, Avalon-MM register access, 32-bit data.
// Notes: Byte addresses are word aligned; reserved bits read as zero.
//
// Overview of operation
// (RULE1) Buffer serial bytes; forward them after the idle interval in 10 ms units.
// (RULE2) An idle interval of zero forwards received serial bytes at once.
// (RULE3) Software should program an idle interval of 11 or more units.
// (RULE4) Pacing 0 to 25 gives each transmitted serial byte that many byte times; the code gives pacing 0 one byte time.
// (RULE5) The no-hold option forwards serial data with the least holding delay.
// (RULE6) Separator sequence of zero to four bytes bounds the packet length.
// (RULE7) After a separator match end packet there, or one or two bytes later.
// (RULE8) With remote control on, changed control line states are exchanged both ways.
// (RULE9) Software sets event byte count to one or more before server/client mode.
// (RULE10) With identifier option, send own hardware address first after connection opens.
// (RULE11) Flag a separator match only when the whole sequence arrived consecutively.
package snp_pkg;
  // Register byte addresses
  localparam logic [7:0] SNP_OFS_CTRL = 8'h00;
  localparam logic [7:0] SNP_OFS_SEP = 8'h04;
  localparam logic [7:0] SNP_OFS_HWID_LO = 8'h08;
  localparam logic [7:0] SNP_OFS_HWID_HI = 8'h0C;
  localparam logic [7:0] SNP_OFS_STATUS = 8'h10;
  // Control register field positions
  localparam int SNP_CTRL_IDLE_LSB = 0;
  localparam int SNP_CTRL_PACE_LSB = 8;
  localparam int SNP_CTRL_SLEN_LSB = 16;
  localparam int SNP_CTRL_SOP_LSB = 20;
  localparam int SNP_CTRL_NOHOLD_BIT = 24;
  localparam int SNP_CTRL_RCTL_BIT = 25;
  localparam int SNP_CTRL_SENDID_BIT = 26;
  // Limits and reset values
  localparam logic [4:0] SNP_PACE_MAX = 5'h19;
  localparam logic [2:0] SNP_SEP_MAX = 3'h4;
  localparam logic [1:0] SNP_SOP_MAX = 2'h2;
  localparam logic [7:0] SNP_IDLE_RST = 8'h00;
  localparam logic [31:0] SNP_SEP_RST = 32'h0000_0000;
  localparam logic [2:0] SNP_ID_BYTES = 3'h6;
  // Timing
  localparam int SNP_CLK_NS = 4;
  localparam int SNP_IDLE_UNIT_NS = 10_000_000;
  localparam int SNP_TICK_CYC = SNP_IDLE_UNIT_NS / SNP_CLK_NS;
  localparam int SNP_BYTE_TIME_CYC = 1000;

  typedef enum logic [1:0] {
    SNP_SOP_SEP_ONLY = 2'b00,
    SNP_SOP_SEP_PLUS1 = 2'b01,
    SNP_SOP_SEP_PLUS2 = 2'b10
  } snp_sep_op_t;

  typedef struct packed {
    logic [7:0] idle;
    logic [4:0] pace;
    logic [2:0] sep_len;
    snp_sep_op_t sep_op;
    logic no_hold;
    logic remote_ctl;
    logic send_hw_identifier;
  } snp_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } snp_byte_t;
endpackage

// ==== core/snp_sep_match.sv ====
// Purpose: Compares the incoming serial byte stream with the separator sequence.
// Assumes: One byte per i_valid cycle; the hit is combinational with that byte.
// Notes: The first separator byte sits in the low byte of i_sep.
module snp_sep_match
  import snp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Byte stream
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  // Separator setting
  input wire logic [2:0] i_len,
  input wire logic [31:0] i_sep,
  // Match
  output logic o_hit
);
  logic [23:0] hist_q;
  logic [2:0] fill_q;
  logic [31:0] window;

  // Window byte j is the byte received j bytes before the newest
  function automatic logic tail_eq(input logic [31:0] win, input logic [31:0] sep, input logic [2:0] len);
    logic eq;
    eq = 1'b1;
    for (int j = 0; j < 4; j++) begin
      if (j < int'(len) && win[8*j +: 8] != sep[8*(int'(len) - 1 - j) +: 8]) begin
        eq = 1'b0;
      end
    end
    return eq;
  endfunction

  assign window = {hist_q, i_byte};
  // (RULE11) Whole sequence in order
  assign o_hit = i_valid && (i_len != 3'h0) && (fill_q >= i_len - 3'h1) && tail_eq(window, i_sep, i_len);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_q <= 24'h00_0000;
      fill_q <= 3'h0;
    end else if (i_valid) begin
      hist_q <= window[23:0];
      fill_q <= (fill_q == 3'h3) ? fill_q : fill_q + 3'h1;
    end
  end

  property p_hit_full;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_hit |-> (i_len <= SNP_SEP_MAX) && (window[7:0] == i_sep[8*(i_len - 3'h1) +: 8]);
  endproperty
  a_hit_full: assert property (p_hit_full) // RULE11
    else $error("separator hit on a wrong newest byte");
endmodule

// ==== core/snp_top.sv ====
// Purpose: Gathers serial bytes into network packets and paces network bytes to the serial side.
// Assumes: Serial and network streams are on i_clk; modem lines are pins.
// Notes: Registers over Avalon-MM; each access answers one cycle after it is seen.
module snp_top
  import snp_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int TICK_CYC = SNP_TICK_CYC,
  parameter int BYTE_TIME_CYC = SNP_BYTE_TIME_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Serial receive stream
  input wire logic i_ser_valid,
  input wire logic [7:0] i_ser_data,
  output logic o_ser_ready,
  // Serial transmit stream
  output logic o_ser_tx_valid,
  output logic [7:0] o_ser_tx_data,
  // Network transmit stream
  output snp_byte_t o_net_tx,
  input wire logic i_net_tx_ready,
  // Network receive stream
  input wire logic i_net_rx_valid,
  input wire logic [7:0] i_net_rx_data,
  output logic o_net_rx_ready,
  // Connection state
  input wire logic i_conn_up,
  // Control lines
  input wire logic [1:0] i_modem_lines,
  output logic [1:0] o_modem_lines,
  input wire logic i_peer_ctl_valid,
  input wire logic [1:0] i_peer_ctl_lines,
  output logic o_ctl_evt,
  output logic [1:0] o_ctl_lines
);
  localparam int AW = $clog2(DEPTH);

  logic rst_meta_q, rst_n;
  snp_cfg_t cfg_q;
  logic [31:0] sep_q;
  logic [47:0] hwid_q;
  logic [7:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q, cm_q, wr_d, rd_d, cm_d, cnt_d;
  logic [7:0] idle_cnt_q;
  logic [31:0] tick_cnt_q;
  logic [1:0] trail_q;
  logic [2:0] id_cnt_q;
  logic conn_q;
  logic [1:0] mdm_meta_q, mdm_q, mdm_prev_q;
  logic [4:0] slot_q;
  logic [31:0] byte_cnt_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Register access decode
  wire acc = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  wire wr_acc = i_avs_write && !o_avs_waitrequest;
  wire sel_ctrl = (i_avs_address == SNP_OFS_CTRL);
  wire sel_sep = (i_avs_address == SNP_OFS_SEP);
  wire sel_lo = (i_avs_address == SNP_OFS_HWID_LO);
  wire sel_hi = (i_avs_address == SNP_OFS_HWID_HI);
  wire sel_st = (i_avs_address == SNP_OFS_STATUS);
  wire [4:0] w_pace = i_avs_writedata[SNP_CTRL_PACE_LSB +: 5];
  wire [2:0] w_slen = i_avs_writedata[SNP_CTRL_SLEN_LSB +: 3];
  wire [1:0] w_sop = i_avs_writedata[SNP_CTRL_SOP_LSB +: 2];
  wire [31:0] ctrl_rd = {5'h00, cfg_q.send_hw_identifier, cfg_q.remote_ctl, cfg_q.no_hold,
                         2'h0, cfg_q.sep_op, 1'b0, cfg_q.sep_len, 3'h0, cfg_q.pace, cfg_q.idle};
  wire [AW:0] used = wr_q - rd_q;
  wire [31:0] status_rd = {11'h000, (id_cnt_q != 3'h0), 7'h00, 9'(used), mdm_q, o_modem_lines};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
                       sel_sep ? sep_q :
                       sel_lo ? hwid_q[31:0] :
                       sel_hi ? {16'h0000, hwid_q[47:32]} :
                       sel_st ? status_rd : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= !acc;
      o_avs_readdata <= (acc && i_avs_read) ? rd_mux : o_avs_readdata;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{idle: SNP_IDLE_RST, sep_op: SNP_SOP_SEP_ONLY, default: '0};
      sep_q <= SNP_SEP_RST;
      hwid_q <= 48'h0000_0000_0000;
    end else if (wr_acc) begin
      if (sel_ctrl) begin
        cfg_q.idle <= i_avs_writedata[SNP_CTRL_IDLE_LSB +: 8];
        // (RULE4) Pacing clamped to 25
        cfg_q.pace <= (w_pace > SNP_PACE_MAX) ? SNP_PACE_MAX : w_pace;
        // (RULE6) Separator length up to four
        cfg_q.sep_len <= (w_slen > SNP_SEP_MAX) ? SNP_SEP_MAX : w_slen;
        cfg_q.sep_op <= snp_sep_op_t'((w_sop > SNP_SOP_MAX) ? SNP_SOP_MAX : w_sop);
        cfg_q.no_hold <= i_avs_writedata[SNP_CTRL_NOHOLD_BIT];
        cfg_q.remote_ctl <= i_avs_writedata[SNP_CTRL_RCTL_BIT];
        cfg_q.send_hw_identifier <= i_avs_writedata[SNP_CTRL_SENDID_BIT];
      end else if (sel_sep) begin
        sep_q <= i_avs_writedata;
      end else if (sel_lo) begin
        hwid_q[31:0] <= i_avs_writedata;
      end else if (sel_hi) begin
        hwid_q[47:32] <= i_avs_writedata[15:0];
      end
    end
  end

  // Serial receive path into the packet buffer
  wire ser_take = i_ser_valid && o_ser_ready;
  logic sep_hit;
  snp_sep_match u_match (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_valid(ser_take),
    .i_byte(i_ser_data),
    .i_len(cfg_q.sep_len),
    .i_sep(sep_q),
    .o_hit(sep_hit)
  );

  wire tick = (tick_cnt_q == 32'(TICK_CYC - 1));
  wire pending = (cm_q != wr_q);
  wire full = (used == (AW + 1)'(DEPTH));
  // (RULE2) Zero interval, (RULE5) no hold: every byte ends a packet
  wire fl_now = cfg_q.no_hold || (cfg_q.idle == 8'h00);
  // (RULE7) End at separator or after trailing bytes
  wire fl_sep = (sep_hit && cfg_q.sep_op == SNP_SOP_SEP_ONLY) || (trail_q == 2'h1);
  wire fl_byte = ser_take && (fl_now || fl_sep);
  // (RULE1) Idle interval elapsed
  wire fl_idle = !ser_take && pending && (cfg_q.idle != 8'h00) && (idle_cnt_q >= cfg_q.idle);
  wire fl_full = !ser_take && full && pending;

  // Network transmit source selection
  wire out_free = !o_net_tx.valid || i_net_tx_ready;
  wire id_send = out_free && (id_cnt_q != 3'h0);
  wire buf_send = out_free && (id_cnt_q == 3'h0) && (rd_q != cm_q);
  wire [47:0] hwid_sh = hwid_q << (8 * (SNP_ID_BYTES - id_cnt_q));

  always_comb begin
    wr_d = ser_take ? wr_q + (AW + 1)'(1) : wr_q;
    rd_d = buf_send ? rd_q + (AW + 1)'(1) : rd_q;
    cm_d = (fl_byte || fl_idle || fl_full) ? wr_d : cm_q;
    cnt_d = wr_d - rd_d;
  end

  always_ff @(posedge i_clk) begin
    if (ser_take) begin
      mem[wr_q[AW-1:0]] <= i_ser_data;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cm_q <= '0;
      o_ser_ready <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cm_q <= cm_d;
      o_ser_ready <= (cnt_d < (AW + 1)'(DEPTH));
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 32'h0000_0000;
      idle_cnt_q <= 8'h00;
      trail_q <= 2'h0;
    end else begin
      tick_cnt_q <= (ser_take || tick) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (ser_take) begin
        idle_cnt_q <= 8'h00;
      end else if (tick && idle_cnt_q != 8'hFF) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
      end
      if (ser_take) begin
        trail_q <= (sep_hit && cfg_q.sep_op != SNP_SOP_SEP_ONLY) ? 2'(cfg_q.sep_op) :
                   (trail_q != 2'h0) ? trail_q - 2'h1 : 2'h0;
      end
    end
  end

  // Identifier insertion and network transmit register
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_q <= 1'b0;
      id_cnt_q <= 3'h0;
      o_net_tx <= '0;
    end else begin
      conn_q <= i_conn_up;
      // (RULE10) Queue identifier on connection open
      if (i_conn_up && !conn_q && cfg_q.send_hw_identifier) begin
        id_cnt_q <= SNP_ID_BYTES;
      end else if (id_send) begin
        id_cnt_q <= id_cnt_q - 3'h1;
      end
      if (id_send) begin
        o_net_tx <= '{valid: 1'b1, data: hwid_sh[47:40], last: (id_cnt_q == 3'h1)};
      end else if (buf_send) begin
        o_net_tx <= '{valid: 1'b1, data: mem[rd_q[AW-1:0]], last: (rd_q + (AW + 1)'(1) == cm_q)};
      end else if (out_free) begin
        o_net_tx <= '0;
      end
    end
  end

  // Paced serial transmit
  wire rx_take = i_net_rx_valid && o_net_rx_ready;
  wire byte_end = (byte_cnt_q == 32'(BYTE_TIME_CYC - 1));
  wire slot_busy = (slot_q != 5'h00);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= 5'h00;
      byte_cnt_q <= 32'h0000_0000;
      o_ser_tx_valid <= 1'b0;
      o_ser_tx_data <= 8'h00;
      o_net_rx_ready <= 1'b0;
    end else begin
      o_ser_tx_valid <= rx_take;
      if (rx_take) begin
        o_ser_tx_data <= i_net_rx_data;
        // (RULE4) Slot of pace byte times
        slot_q <= (cfg_q.pace == 5'h00) ? 5'h01 : cfg_q.pace;
        // Take cycle counts as the first of the slot; byte time of two or more
        byte_cnt_q <= 32'h0000_0001;
      end else if (slot_busy) begin
        byte_cnt_q <= byte_end ? 32'h0000_0000 : byte_cnt_q + 32'h0000_0001;
        slot_q <= byte_end ? slot_q - 5'h01 : slot_q;
      end
      o_net_rx_ready <= !rx_take && !(slot_busy && !(byte_end && slot_q == 5'h01));
    end
  end

  // Control line exchange
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdm_meta_q <= 2'h0;
      mdm_q <= 2'h0;
      mdm_prev_q <= 2'h0;
      o_ctl_evt <= 1'b0;
      o_ctl_lines <= 2'h0;
      o_modem_lines <= 2'h0;
    end else begin
      mdm_meta_q <= i_modem_lines;
      mdm_q <= mdm_meta_q;
      mdm_prev_q <= mdm_q;
      // (RULE8) Report local change, apply peer state
      o_ctl_evt <= cfg_q.remote_ctl && (mdm_q != mdm_prev_q);
      o_ctl_lines <= mdm_q;
      if (cfg_q.remote_ctl && i_peer_ctl_valid) begin
        o_modem_lines <= i_peer_ctl_lines;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_id_open;
    i_conn_up && !conn_q && cfg_q.send_hw_identifier && id_cnt_q == 3'h0;
  endsequence
  sequence s_first_id_byte;
    ##[1:300] o_net_tx.valid && o_net_tx.data == hwid_q[47:40];
  endsequence
  property p_idle_zero;
    ser_take && cfg_q.idle == 8'h00 |=> cm_q == wr_q;
  endproperty
  a_idle_zero: assert property (p_idle_zero) // RULE2
    else $error("zero interval did not forward at once");
  property p_idle_flush;
    fl_idle |=> cm_q == $past(wr_q);
  endproperty
  a_idle_flush: assert property (p_idle_flush) // RULE1
    else $error("idle interval did not end the packet");
  property p_no_hold;
    ser_take && cfg_q.no_hold |=> cm_q == wr_q;
  endproperty
  a_no_hold: assert property (p_no_hold) // RULE5
    else $error("no-hold byte was held");
  property p_sep_end;
    sep_hit && cfg_q.sep_op == SNP_SOP_SEP_ONLY |=> cm_q == wr_q;
  endproperty
  a_sep_end: assert property (p_sep_end) // RULE7
    else $error("separator did not end the packet");
  property p_sep_len;
    cfg_q.sep_len <= SNP_SEP_MAX && cfg_q.pace <= SNP_PACE_MAX;
  endproperty
  a_sep_len: assert property (p_sep_len) // RULE6
    else $error("separator length or pacing out of range");
  property p_pace_out;
    rx_take |=> o_ser_tx_valid && o_ser_tx_data == $past(i_net_rx_data) && !o_net_rx_ready;
  endproperty
  a_pace_out: assert property (p_pace_out) // RULE4
    else $error("paced byte not sent or slot not held");
  property p_pace_hold;
    slot_q > 5'h01 |-> !o_net_rx_ready;
  endproperty
  a_pace_hold: assert property (p_pace_hold) // RULE4
    else $error("serial slot accepted a byte early");
  property p_id_first;
    s_id_open |-> s_first_id_byte;
  endproperty
  a_id_first: assert property (p_id_first) // RULE10
    else $error("identifier not sent after connection");
  property p_id_block;
    id_cnt_q != 3'h0 && out_free |=> o_net_tx.valid && rd_q == $past(rd_q);
  endproperty
  a_id_block: assert property (p_id_block) // RULE10
    else $error("buffered data overtook the identifier");
  property p_ctl_evt;
    cfg_q.remote_ctl && mdm_q != mdm_prev_q |=> o_ctl_evt && o_ctl_lines == $past(mdm_q);
  endproperty
  a_ctl_evt: assert property (p_ctl_evt) // RULE8
    else $error("control line change not reported");
endmodule

// ==== bench/snp_far_end.sv ====
// Purpose: Serial device and network stack model facing the packetizer.
// Assumes: Single clock; bytes are offered by the send task right after an edge.
// Notes: A released serial data line shows the inverse of the last byte.
module snp_far_end
  import snp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial device side
  output logic o_ser_valid,
  output logic [7:0] o_ser_data,
  input wire logic i_ser_ready,
  // Network stack side
  input wire snp_byte_t i_net_tx,
  output logic o_net_tx_ready,
  input wire logic i_stall
);
  logic [7:0] got_q[$];
  logic last_q[$];
  logic [1:0] cnt_q;

  initial begin
    o_ser_valid = 1'b0;
    o_ser_data = 8'hA5;
  end

  // Each byte is held until the block takes it
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      o_ser_valid <= 1'b1;
      o_ser_data <= b[i];
      do @(posedge i_clk); while (i_ser_ready !== 1'b1);
    end
    o_ser_valid <= 1'b0;
    o_ser_data <= ~b[b.size()-1];
  endtask

  // Sink accepts one cycle in four while stalling
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 2'h0;
      o_net_tx_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      o_net_tx_ready <= !i_stall || (cnt_q == 2'h0);
      if (i_net_tx.valid === 1'b1 && o_net_tx_ready) begin
        got_q.push_back(i_net_tx.data);
        last_q.push_back(i_net_tx.last);
      end
    end
  end
endmodule

// ==== bench/tb.sv ====
// Purpose: Self-checking bench of the serial-to-network packetizer.
// Assumes: Shortened tick of 20 cycles and byte time of 4 cycles.
// Notes: Registers are reached through Avalon-MM tasks.
module tb
  import snp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  localparam int BT = 4;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wait_req, ser_valid, ser_ready;
  logic [7:0] addr = 8'h00, ser_data, tx_data, nrx_data = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, c0;
  logic tx_valid, net_tx_ready, nrx_valid = 1'b0, nrx_ready, conn_up = 1'b0, pctl_valid = 1'b0;
  logic ctl_evt, stall = 1'b1;
  logic [1:0] mlin = 2'h0, mlout, pctl = 2'h0, ctl_lines;
  snp_byte_t net_tx;
  int fails = 0, n_checks = 0, cyc = 0, evt_n = 0;
  int tx_t[$];
  logic [7:0] tx_d[$];

  always #2 clk = ~clk;

  snp_top #(.TICK_CYC(TICK), .BYTE_TIME_CYC(BT)) snp_top_i (
    .i_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
    .i_ser_valid(ser_valid), .i_ser_data(ser_data), .o_ser_ready(ser_ready),
    .o_ser_tx_valid(tx_valid), .o_ser_tx_data(tx_data), .o_net_tx(net_tx), .i_net_tx_ready(net_tx_ready),
    .i_net_rx_valid(nrx_valid), .i_net_rx_data(nrx_data), .o_net_rx_ready(nrx_ready), .i_conn_up(conn_up),
    .i_modem_lines(mlin), .o_modem_lines(mlout), .i_peer_ctl_valid(pctl_valid),
    .i_peer_ctl_lines(pctl), .o_ctl_evt(ctl_evt), .o_ctl_lines(ctl_lines));

  snp_far_end far_end_i (
    .i_clk(clk), .i_rst_n(rst_n), .o_ser_valid(ser_valid), .o_ser_data(ser_data),
    .i_ser_ready(ser_ready), .i_net_tx(net_tx), .o_net_tx_ready(net_tx_ready), .i_stall(stall));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cycle count, serial output and line event monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid === 1'b1) begin
      tx_t.push_back(cyc);
      tx_d.push_back(tx_data);
    end
    if (ctl_evt === 1'b1) evt_n++;
    if (cyc == LIMIT) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    chk(rdata, e, "register read");
    rd <= 1'b0;
  endtask

  function automatic logic [31:0] cfg(input int idle, pace, len, op, nh, rc, id);
    cfg = 32'h0;
    cfg[SNP_CTRL_IDLE_LSB +: 8] = idle[7:0];
    cfg[SNP_CTRL_PACE_LSB +: 5] = pace[4:0];
    cfg[SNP_CTRL_SLEN_LSB +: 3] = len[2:0];
    cfg[SNP_CTRL_SOP_LSB +: 2] = op[1:0];
    cfg[SNP_CTRL_NOHOLD_BIT] = nh[0];
    cfg[SNP_CTRL_RCTL_BIT] = rc[0];
    cfg[SNP_CTRL_SENDID_BIT] = id[0];
  endfunction

  task automatic wait_net(input int n);
    for (int k = 0; k < 2000 && far_end_i.got_q.size() < n; k++) @(posedge clk);
  endtask

  // Pops one whole packet and compares bytes and end mark
  task automatic chk_net(input logic [7:0] e[$]);
    wait_net(e.size());
    for (int i = 0; i < e.size(); i++) begin
      chk({24'h0, far_end_i.got_q.pop_front()}, {24'h0, e[i]}, "net byte");
      chk({31'h0, far_end_i.last_q.pop_front()}, {31'h0, i == e.size() - 1}, "packet end");
    end
  endtask

  task automatic sep_case(input logic [31:0] sep, input int len, op, n1, input logic [7:0] s[$]);
    wr_reg(SNP_OFS_SEP, sep);
    wr_reg(SNP_OFS_CTRL, cfg(11, 0, len, op, 0, 0, 0));
    far_end_i.send(s);
    chk_net(s[0:n1-1]);
    chk_net(s[n1:$]);
  endtask

  // Measures the slot between two paced serial bytes
  task automatic pace_case(input int p);
    wr_reg(SNP_OFS_CTRL, cfg(11, p, 0, 0, 0, 0, 0));
    tx_t.delete();
    tx_d.delete();
    @(posedge clk);
    nrx_valid <= 1'b1;
    nrx_data <= 8'h3C;
    do @(posedge clk); while (nrx_ready !== 1'b1);
    nrx_data <= 8'hC3;
    do @(posedge clk); while (nrx_ready !== 1'b1);
    nrx_valid <= 1'b0;
    nrx_data <= 8'h3C;
    for (int k = 0; k < 400 && tx_t.size() < 2; k++) @(posedge clk);
    chk(tx_t[1] - tx_t[0], ((p == 0) ? 1 : p) * BT, "pacing slot");
    chk({tx_d[0], tx_d[1]}, 16'h3CC3, "serial bytes");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk_rd(SNP_OFS_CTRL, 32'h0);
    chk_rd(SNP_OFS_SEP, SNP_SEP_RST);
    chk_rd(SNP_OFS_STATUS, 32'h0);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    chk_rd(8'h20, 32'h0);
    wr_reg(SNP_OFS_CTRL, cfg(11, 31, 7, 3, 0, 0, 0));
    chk_rd(SNP_OFS_CTRL, cfg(11, 25, 4, 2, 0, 0, 0));
    $display("test registers done");
    wr_reg(SNP_OFS_HWID_LO, 32'h3344_5566);
    wr_reg(SNP_OFS_HWID_HI, 32'h0000_1122);
    chk_rd(SNP_OFS_HWID_LO, 32'h3344_5566);
    chk_rd(SNP_OFS_HWID_HI, 32'h0000_1122);
    wr_reg(SNP_OFS_CTRL, cfg(11, 0, 0, 0, 0, 0, 1));
    // Plain connection only; no combined server and client mode
    conn_up <= 1'b1;
    far_end_i.send('{8'h77});
    chk_rd(SNP_OFS_STATUS, 32'h0010_0010);
    chk_net('{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
    chk_net('{8'h77});
    stall <= 1'b0;
    $display("test identifier done");
    wr_reg(SNP_OFS_CTRL, cfg(11, 0, 0, 0, 0, 0, 0));
    far_end_i.send('{8'h01, 8'h02, 8'h03});
    c0 = cyc;
    wait_net(1);
    d = cyc - c0;
    chk(d >= 10 * TICK && d <= 13 * TICK, 1, "idle flush time");
    chk_net('{8'h01, 8'h02, 8'h03});
    for (int nh = 0; nh < 2; nh++) begin
      wr_reg(SNP_OFS_CTRL, cfg(nh ? 11 : 0, 0, 0, 0, nh, 0, 0));
      far_end_i.send('{8'h44});
      c0 = cyc;
      wait_net(1);
      chk(cyc - c0 <= 12, 1, "prompt forward");
      chk_net('{8'h44});
    end
    $display("test idle done");
    for (int op = 0; op < 3; op++) begin
      sep_case(32'h0000_0A0D, 2, op, 4 + op, '{8'h0D, 8'h41, 8'h0D, 8'h0A, 8'h61, 8'h62, 8'h63});
    end
    sep_case(32'h0403_0201, 4, 0, 7, '{8'h01, 8'h02, 8'h03, 8'h01, 8'h02, 8'h03, 8'h04, 8'h09});
    $display("test separator done");
    pace_case(0);
    pace_case(3);
    pace_case(25);
    $display("test pacing done");
    wr_reg(SNP_OFS_CTRL, cfg(11, 0, 0, 0, 0, 1, 0));
    c0 = evt_n;
    mlin <= 2'b10;
    repeat (10) @(posedge clk);
    chk(evt_n - c0, 1, "line event");
    chk({30'h0, ctl_lines}, 32'h2, "local lines");
    pctl_valid <= 1'b1;
    pctl <= 2'b01;
    @(posedge clk);
    pctl_valid <= 1'b0;
    @(posedge clk);
    chk({30'h0, mlout}, 32'h1, "peer lines");
    wr_reg(SNP_OFS_CTRL, cfg(11, 0, 0, 0, 0, 0, 0));
    c0 = evt_n;
    mlin <= 2'b01;
    pctl_valid <= 1'b1;
    pctl <= 2'b10;
    @(posedge clk);
    pctl_valid <= 1'b0;
    repeat (10) @(posedge clk);
    chk(evt_n - c0, 0, "event while off");
    chk({30'h0, mlout}, 32'h1, "peer lines while off");
    $display("test control lines done");
    report_and_stop();
  end
endmodule
